/* File: design/ums_brk_detect.sv */
// Purpose: Watches the received data line for a break and for the recovery after it.
// Assumes: i_sample_en pulses sixteen times per bit from the baud divider.
// Notes: One zero character is requested per break, however long the line stays low.
`include "ums_defines.svh"
`timescale 1ns/1ns
module ums_brk_detect (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_sample_en,
  input wire logic i_rxd,
  input wire logic [7:0] i_char_samples,
  output logic o_push,
  output logic o_start_ok
);
  ums_pkg::ums_brk_state_t s_reg;
  ums_pkg::ums_brk_state_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.push = 1'b0;
    if (i_sample_en) begin
      case (s_reg.st)
        ums_pkg::UMS_BRK_IDLE: begin
          s_next.cnt = 8'h00;
          if (!i_rxd) begin
            s_next.st = ums_pkg::UMS_BRK_LOW;
            s_next.cnt = 8'h01;
          end
        end
        ums_pkg::UMS_BRK_LOW: begin
          if (i_rxd) begin
            s_next.st = ums_pkg::UMS_BRK_IDLE;
          end else if (s_reg.cnt > i_char_samples) begin
            s_next.st = ums_pkg::UMS_BRK_HELD; // [RULE9]
            s_next.push = 1'b1; // [RULE12]
            s_next.start_ok = 1'b0;
          end else begin
            s_next.cnt = s_reg.cnt + 8'h01;
          end
        end
        ums_pkg::UMS_BRK_HELD: begin
          s_next.cnt = 8'h00;
          if (i_rxd) begin
            s_next.st = ums_pkg::UMS_BRK_RECOVER;
            s_next.cnt = 8'h01;
          end
        end
        ums_pkg::UMS_BRK_RECOVER: begin
          if (!i_rxd) begin
            s_next.st = ums_pkg::UMS_BRK_HELD;
          end else if (s_reg.cnt >= `UMS_HALF_BIT_SAMPLES) begin
            s_next.st = ums_pkg::UMS_BRK_IDLE; // [RULE13]
            s_next.start_ok = 1'b1;
          end else begin
            s_next.cnt = s_reg.cnt + 8'h01;
          end
        end
        default: begin
          s_next.st = ums_pkg::UMS_BRK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_reg <= '{st: ums_pkg::UMS_BRK_IDLE, cnt: 8'h00, push: 1'b0, start_ok: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_push = s_reg.push;
  assign o_start_ok = s_reg.start_ok;

  a_one_push: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    s_reg.push |=> !s_reg.push) else $error("break push longer than one cycle"); // [RULE12]
endmodule

/* File: design/ums_defines.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the line status block.
// Assumes: Register offsets are 4-bit indexes on the plain register port.
// Notes: Definitions only.
`ifndef UMS_DEFINES_SVH
`define UMS_DEFINES_SVH
`define UMS_OFF_TX_HOLD 4'h0
`define UMS_OFF_INT_EN 4'h1
`define UMS_OFF_FIFO_CTL 4'h2
`define UMS_OFF_LINE_CTL 4'h3
`define UMS_OFF_MODEM_CTL 4'h4
`define UMS_OFF_LINE_STATUS 4'h5
`define UMS_OFF_EVT_STATUS 4'h8
`define UMS_OFF_EVT_CLEAR 4'h9
`define UMS_OFF_EVT_ENABLE 4'ha
`define UMS_MC_DTR 0
`define UMS_MC_RTS 1
`define UMS_LS_OVERRUN 1
`define UMS_LS_PARITY 2
`define UMS_LS_FRAMING 3
`define UMS_LS_BREAK 4
`define UMS_LS_HOLD_EMPTY 5
`define UMS_LS_TX_IDLE 6
`define UMS_LS_FIFO_ERR 7
`define UMS_IE_LINE 0
`define UMS_IE_HOLD 1
`define UMS_EVT_LINE 0
`define UMS_EVT_HOLD 1
`define UMS_RST_MODEM_CTL 5'h00
`define UMS_RST_LINE_CTL 4'h3
`define UMS_SAMPLES_PER_BIT 8'h10
`define UMS_HALF_BIT_SAMPLES 8'h08
`endif

/* File: design/ums_line_status.sv */
// Purpose: Modem handshake outputs and line status flags of a serial port.
// Assumes: Transmit and receive paths sit outside and report their events as inputs.
// Notes: All outputs are registered; reads answer one cycle after the read strobe.
// Contract
// RULE1 - Modem control bit 1 set drives the request-to-send pin low, clear drives it high.
// RULE2 - Modem control bit 0 set drives the terminal-ready pin low, clear drives it high.
// RULE3 - Outside FIFO mode line status bit 7 always reads zero.
// RULE4 - In FIFO mode bit 7 is set while a tagged character is held and a read clears it only once none remains.
// RULE5 - Bit 6 is one exactly when holding and shift registers are both empty, read-only.
// RULE6 - Outside FIFO mode bit 5 sets on a move into the shift register and clears on a holding register write.
// RULE7 - In FIFO mode bit 5 follows an empty transmit FIFO and clears as soon as one byte is written.
// RULE8 - Bit 5 with its interrupt enable set raises the serial port interrupt; here o_irq also needs evt_en bit 1 set.
// RULE9 - Bit 4 sets when the data input stays low for longer than one character time.
// RULE10 - A read of line status clears the break flag; here a read in the cycle a new entry reaches the head keeps it set.
// RULE11 - In FIFO mode a break is kept with its entry and shown only when that entry reaches the head.
// RULE12 - Each break loads exactly one zero character into the receive FIFO.
// RULE13 - After a break no new character starts before the input has been high for half a bit.
// RULE14 - Any of bits 1 to 4 becoming set raises the receiver line status interrupt when enabled.
// RULE15 - Bit 3 sets for a character whose stop bit was zero and clears on a line status read; here a read in the cycle a new entry reaches the head keeps it.
// RULE16 - Bit 1 sets at once on an overrun, in FIFO mode only when full, and clears on a read.
// RULE17 - Only a read of the line status offset clears its flags.
`include "ums_defines.svh"
`timescale 1ns/1ns
module ums_line_status #(
  parameter int RX_DEPTH = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [7:0] o_rd_data,
  input wire logic i_sample_en,
  input wire logic i_rxd,
  input wire logic i_rx_push,
  input wire logic i_rx_perr,
  input wire logic i_rx_ferr,
  input wire logic i_rx_pop,
  input wire logic i_tx_load,
  input wire logic i_tsr_empty,
  input wire logic i_txf_empty,
  output logic o_rts_n,
  output logic o_dtr_n,
  output logic o_brk_char_push,
  output logic o_rx_start_ok,
  output logic o_irq
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  ums_pkg::ums_main_state_t s_reg;
  ums_pkg::ums_main_state_t s_next;
  ums_pkg::ums_tag_t rx_tag;
  ums_pkg::ums_tag_t head_tag;
  logic head_new;
  logic rx_full;
  logic err_any;
  logic brk_push;
  logic start_ok;
  logic ls_read;
  logic hold_wr;
  logic [7:0] ls_value;
  logic [3:0] low_flags_next;

  // Character time in sixteenth-bit samples: start, data and parity bits plus any second stop bit.
  function automatic logic [7:0] char_samples(input logic [3:0] lc);
    logic [7:0] bits;
    bits = 8'h06 + {6'h00, lc[1:0]} + {7'h00, lc[3]} + {7'h00, lc[2]};
    char_samples = 8'(bits * `UMS_SAMPLES_PER_BIT);
  endfunction

  function automatic logic is_access(input logic en, input logic [3:0] a, input logic [3:0] off);
    is_access = en && a == off;
  endfunction

  assign rx_tag = '{brk: brk_push, ferr: i_rx_ferr & ~brk_push, perr: i_rx_perr & ~brk_push};

  ums_brk_detect u_brk (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_sample_en(i_sample_en),
    .i_rxd(i_rxd),
    .i_char_samples(char_samples(s_reg.line_ctl)),
    .o_push(brk_push),
    .o_start_ok(start_ok)
  );

  ums_rx_tags #(
    .DEPTH(RX_DEPTH)
  ) u_tags (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_fifo_mode(s_reg.fifo_mode),
    .i_push(i_rx_push | brk_push),
    .i_tag(rx_tag),
    .i_pop(i_rx_pop),
    .o_head(head_tag),
    .o_head_new(head_new),
    .o_full(rx_full),
    .o_err_any(err_any)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    ls_read = is_access(i_rd_en, i_addr, `UMS_OFF_LINE_STATUS); // [RULE17]
    hold_wr = is_access(i_wr_en, i_addr, `UMS_OFF_TX_HOLD);
    ls_value = 8'h00;
    ls_value[`UMS_LS_OVERRUN] = s_reg.ls_overrun;
    ls_value[`UMS_LS_PARITY] = s_reg.ls_parity;
    ls_value[`UMS_LS_FRAMING] = s_reg.ls_framing;
    ls_value[`UMS_LS_BREAK] = s_reg.ls_break;
    ls_value[`UMS_LS_HOLD_EMPTY] = s_reg.hold_empty;
    ls_value[`UMS_LS_TX_IDLE] = s_reg.tx_idle;
    ls_value[`UMS_LS_FIFO_ERR] = s_reg.fifo_err & s_reg.fifo_mode; // [RULE3]
    s_next = s_reg;

    if (i_wr_en) begin
      case (i_addr)
        `UMS_OFF_INT_EN: s_next.int_en = i_wr_data[1:0];
        `UMS_OFF_FIFO_CTL: s_next.fifo_mode = i_wr_data[0];
        `UMS_OFF_LINE_CTL: s_next.line_ctl = i_wr_data[3:0];
        `UMS_OFF_MODEM_CTL: s_next.modem_ctl = i_wr_data[4:0];
        `UMS_OFF_EVT_ENABLE: s_next.evt_en = i_wr_data[1:0];
        `UMS_OFF_EVT_CLEAR: s_next.evt_status = s_reg.evt_status & ~i_wr_data[1:0];
        default: s_next.modem_ctl = s_reg.modem_ctl;
      endcase
    end

    // Overrun clears first so that an event in the same cycle still sets it; a new head in the same cycle keeps the old parity, framing and break flags.
    if (ls_read) begin
      s_next.ls_overrun = 1'b0; // [RULE16]
      s_next.ls_parity = 1'b0;
      s_next.ls_framing = 1'b0; // [RULE15]
      s_next.ls_break = 1'b0; // [RULE10]
    end
    if ((i_rx_push | brk_push) && rx_full && !i_rx_pop) begin
      s_next.ls_overrun = 1'b1; // [RULE16]
    end
    if (head_new) begin
      s_next.ls_parity = s_reg.ls_parity | head_tag.perr;
      s_next.ls_framing = s_reg.ls_framing | head_tag.ferr; // [RULE15]
      s_next.ls_break = s_reg.ls_break | head_tag.brk; // [RULE11]
    end

    if (err_any) begin
      s_next.fifo_err = 1'b1; // [RULE4]
    end else if (ls_read) begin
      s_next.fifo_err = 1'b0; // [RULE4]
    end

    if (s_reg.fifo_mode) begin
      s_next.hold_empty = i_txf_empty && !hold_wr; // [RULE7]
    end else if (i_tx_load) begin
      s_next.hold_empty = 1'b1; // [RULE6]
    end else if (hold_wr) begin
      s_next.hold_empty = 1'b0; // [RULE6]
    end
    s_next.tx_idle = s_next.hold_empty && i_tsr_empty; // [RULE5]

    low_flags_next = {s_next.ls_break, s_next.ls_framing, s_next.ls_parity, s_next.ls_overrun};
    if ((low_flags_next & ~{s_reg.ls_break, s_reg.ls_framing, s_reg.ls_parity, s_reg.ls_overrun})
        != 4'h0 && s_reg.int_en[`UMS_IE_LINE]) begin
      s_next.evt_status[`UMS_EVT_LINE] = 1'b1; // [RULE14]
    end
    // A level source: the bit keeps setting while the flag stays up, so a clear only sticks
    // once the holding register has been refilled.
    if (s_reg.hold_empty && s_reg.int_en[`UMS_IE_HOLD]) begin
      s_next.evt_status[`UMS_EVT_HOLD] = 1'b1; // [RULE8]
    end
    s_next.irq = (s_next.evt_status & s_next.evt_en) != 2'h0;

    s_next.rd_data = 8'h00;
    if (i_rd_en) begin
      case (i_addr)
        `UMS_OFF_INT_EN: s_next.rd_data = {6'h00, s_reg.int_en};
        `UMS_OFF_FIFO_CTL: s_next.rd_data = {7'h00, s_reg.fifo_mode};
        `UMS_OFF_LINE_CTL: s_next.rd_data = {4'h0, s_reg.line_ctl};
        `UMS_OFF_MODEM_CTL: s_next.rd_data = {3'h0, s_reg.modem_ctl};
        `UMS_OFF_LINE_STATUS: s_next.rd_data = ls_value;
        `UMS_OFF_EVT_STATUS: s_next.rd_data = {6'h00, s_reg.evt_status};
        `UMS_OFF_EVT_ENABLE: s_next.rd_data = {6'h00, s_reg.evt_en};
        default: s_next.rd_data = 8'h00;
      endcase
    end

    s_next.rts_n = !s_next.modem_ctl[`UMS_MC_RTS]; // [RULE1]
    s_next.dtr_n = !s_next.modem_ctl[`UMS_MC_DTR]; // [RULE2]
    s_next.brk_push = brk_push; // [RULE12]
    s_next.start_ok = start_ok; // [RULE13]
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_reg <= '0;
      s_reg.modem_ctl <= `UMS_RST_MODEM_CTL;
      s_reg.line_ctl <= `UMS_RST_LINE_CTL;
      s_reg.rts_n <= 1'b1;
      s_reg.dtr_n <= 1'b1;
      s_reg.start_ok <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_rd_data = s_reg.rd_data;
  assign o_rts_n = s_reg.rts_n;
  assign o_dtr_n = s_reg.dtr_n;
  assign o_brk_char_push = s_reg.brk_push;
  assign o_rx_start_ok = s_reg.start_ok;
  assign o_irq = s_reg.irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_rts_follows: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_wr_en && i_addr == `UMS_OFF_MODEM_CTL) |=> o_rts_n == !$past(i_wr_data[1]))
    else $error("request-to-send pin does not follow control bit"); // [RULE1]
  a_dtr_follows: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_wr_en && i_addr == `UMS_OFF_MODEM_CTL) |=> o_dtr_n == !$past(i_wr_data[0]))
    else $error("terminal-ready pin does not follow control bit"); // [RULE2]
  a_fifo_err_450: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_rd_en && i_addr == `UMS_OFF_LINE_STATUS && !s_reg.fifo_mode) |=> !o_rd_data[7])
    else $error("fifo error bit read as one outside fifo mode"); // [RULE3]
  a_fifo_err_held: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    err_any |=> s_reg.fifo_err) else $error("fifo error flag lost while tags remain"); // [RULE4]
  a_tx_idle_both: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    s_reg.tx_idle |-> s_reg.hold_empty && $past(i_tsr_empty))
    else $error("transmitter idle while a register holds data"); // [RULE5]
  a_hold_clears: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_wr_en && i_addr == `UMS_OFF_TX_HOLD && !i_tx_load) |=> !s_reg.hold_empty)
    else $error("holding empty flag still set after a write"); // [RULE6]
  a_hold_sets: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_tx_load && !s_reg.fifo_mode) |=> s_reg.hold_empty)
    else $error("holding empty flag missed a load"); // [RULE6]
  a_hold_irq: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (s_reg.hold_empty && s_reg.int_en[1] && s_reg.evt_en[1]) |=> ##1 o_irq)
    else $error("holding empty interrupt not raised"); // [RULE8]
  a_break_clear: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_rd_en && i_addr == `UMS_OFF_LINE_STATUS && !head_new) |=> !s_reg.ls_break)
    else $error("break flag survived a line status read"); // [RULE10]
  a_other_keeps: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (s_reg.ls_framing && !(i_rd_en && i_addr == `UMS_OFF_LINE_STATUS)) |=> s_reg.ls_framing)
    else $error("framing flag cleared without a line status read"); // [RULE17]
  a_line_event: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    ($rose(s_reg.ls_overrun) && $past(s_reg.int_en[0])) |-> s_reg.evt_status[0])
    else $error("line status event missed"); // [RULE14]
  a_brk_char: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    o_brk_char_push |=> !o_brk_char_push [*8])
    else $error("second zero character within one break"); // [RULE12]

  c_break_seen: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    o_brk_char_push ##[1:1000] s_reg.ls_break);
  c_overrun: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    $rose(s_reg.ls_overrun));
  c_hold_irq: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    s_reg.hold_empty && o_irq);
  c_fifo_err: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    s_reg.fifo_mode && s_reg.fifo_err ##1 !s_reg.fifo_err);
endmodule

/* File: design/ums_pkg.sv */
// Purpose: Types shared by the line status block and its helpers.
// Assumes: Nothing beyond the defines header.
// Notes: Every design module keeps its state in one of these structs, except the tag memory of ums_rx_tags.
package ums_pkg;

  typedef struct packed {
    logic brk;
    logic ferr;
    logic perr;
  } ums_tag_t;

  typedef enum logic [1:0] {
    UMS_BRK_IDLE,
    UMS_BRK_LOW,
    UMS_BRK_HELD,
    UMS_BRK_RECOVER
  } ums_brk_st_t;

  typedef struct packed {
    ums_brk_st_t st;
    logic [7:0] cnt;
    logic push;
    logic start_ok;
  } ums_brk_state_t;

  typedef struct packed {
    logic [4:0] wr;
    logic [4:0] rd;
    logic [5:0] count;
    logic [5:0] err_cnt;
    logic head_new;
  } ums_tags_state_t;

  typedef struct packed {
    logic [4:0] modem_ctl;
    logic [1:0] int_en;
    logic fifo_mode;
    logic [3:0] line_ctl;
    logic ls_overrun;
    logic ls_parity;
    logic ls_framing;
    logic ls_break;
    logic hold_empty;
    logic tx_idle;
    logic fifo_err;
    logic [1:0] evt_status;
    logic [1:0] evt_en;
    logic [7:0] rd_data;
    logic irq;
    logic rts_n;
    logic dtr_n;
    logic brk_push;
    logic start_ok;
  } ums_main_state_t;

endpackage

/* File: design/ums_rx_tags.sv */
// Purpose: Keeps the error tags of every character in the receive FIFO.
// Assumes: Pushes and pops mirror the receive data FIFO one for one.
// Notes: Outside FIFO mode the store behaves as a single holding slot.
`timescale 1ns/1ns
module ums_rx_tags #(
  parameter int DEPTH = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_fifo_mode,
  input wire logic i_push,
  input wire ums_pkg::ums_tag_t i_tag,
  input wire logic i_pop,
  output ums_pkg::ums_tag_t o_head,
  output logic o_head_new,
  output logic o_full,
  output logic o_err_any
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || DEPTH > 16 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("DEPTH must be a power of two from 2 to 16");
    end
  end

  ums_pkg::ums_tag_t mem [DEPTH];
  ums_pkg::ums_tags_state_t s_reg;
  ums_pkg::ums_tags_state_t s_next;
  logic full;
  logic do_push;
  logic do_pop;

  function automatic logic has_err(input ums_pkg::ums_tag_t t);
    has_err = t.brk | t.ferr | t.perr;
  endfunction

  always_comb begin
    full = i_fifo_mode ? (s_reg.count == 6'(DEPTH)) : (s_reg.count != 6'h00);
    do_pop = i_pop && s_reg.count != 6'h00;
    do_push = i_push && (!full || do_pop);
    s_next = s_reg;
    s_next.head_new = (do_push && (s_reg.count == 6'h00 || (do_pop && s_reg.count == 6'h01)))
      || (do_pop && s_reg.count > 6'h01);
    if (do_push) begin
      s_next.wr = 5'((s_reg.wr + 5'h01) & 5'(DEPTH - 1));
    end
    if (do_pop) begin
      s_next.rd = 5'((s_reg.rd + 5'h01) & 5'(DEPTH - 1));
    end
    s_next.count = s_reg.count + {5'h00, do_push} - {5'h00, do_pop};
    s_next.err_cnt = s_reg.err_cnt + {5'h00, do_push && has_err(i_tag)}
      - {5'h00, do_pop && has_err(mem[s_reg.rd[AW-1:0]])};
  end

  always_ff @(posedge i_clk_sys) begin
    if (do_push) begin
      mem[s_reg.wr[AW-1:0]] <= i_tag; // [RULE11]
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_head = mem[s_reg.rd[AW-1:0]];
  assign o_head_new = s_reg.head_new;
  assign o_full = full;
  assign o_err_any = s_reg.err_cnt != 6'h00;

  a_count_bound: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    s_reg.err_cnt <= s_reg.count) else $error("more tagged entries than entries"); // [RULE4]
endmodule

/* File: tb/test_uart_modem_out_line_status.sv */
// Purpose: Self-checking bench of the modem outputs and line status flags.
// Assumes: Eight data bits, no parity and one stop bit after reset.
// Notes: Random modem control values come from a fixed-seed shift register.
`include "ums_defines.svh"
`timescale 1ns/1ns
module test_uart_modem_out_line_status;
  // ************************************************************
  // Signals and helpers
  // ************************************************************
  localparam logic [3:0] ls = `UMS_OFF_LINE_STATUS;
  localparam logic [3:0] transmit_holding_register = `UMS_OFF_TX_HOLD;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, se = 1'b0;
  logic push = 1'b0, perr = 1'b0, ferr = 1'b0, pop = 1'b0;
  logic load = 1'b0, tsr_e = 1'b1, txf_e = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wd = 8'h00;
  logic [7:0] rdat;
  logic rts_n, dtr_n, bpush, start_ok, irq, rxd;
  int n_fail = 0, n_checks = 0, n_bpush = 0;
  logic [31:0] lfsr = 32'h00014c60;

  always #2 clk = ~clk;
  always @(posedge clk) se <= ~se;
  always @(posedge clk) if (bpush === 1'b1) n_bpush++;

  ums_line_status u_ums_line_status (.i_clk_sys(clk), .i_reset_n(rst_n), .i_addr(addr),
    .i_wr_data(wd), .i_wr_en(wr), .i_rd_en(rd), .o_rd_data(rdat), .i_sample_en(se),
    .i_rxd(rxd), .i_rx_push(push), .i_rx_perr(perr), .i_rx_ferr(ferr), .i_rx_pop(pop),
    .i_tx_load(load), .i_tsr_empty(tsr_e), .i_txf_empty(txf_e), .o_rts_n(rts_n),
    .o_dtr_n(dtr_n), .o_brk_char_push(bpush), .o_rx_start_ok(start_ok), .o_irq(irq));
  ums_line_partner u_ums_line_partner (.i_clk_sys(clk), .i_sample_en(se), .o_rxd(rxd));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] exp_pins(input logic [7:0] mc);
    return {6'h00, ~mc[`UMS_MC_RTS], ~mc[`UMS_MC_DTR]};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdat;
    @(posedge clk);
  endtask
  task automatic pulse_load();
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    step(3);
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask
  task automatic stop_test();
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    logic [7:0] v;
    logic [7:0] mc;
    do_reset();
    chk({6'h00, rts_n, dtr_n}, 8'h03);
    rd_reg(ls, v); chk(v, 8'h00);
    rd_reg(4'h7, v); chk(v, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      mc = {3'h0, lfsr[4:0]};
      if (i < 4) mc[1:0] = i[1:0];
      wr_reg(`UMS_OFF_MODEM_CTL, mc);
      step(1);
      chk({6'h00, rts_n, dtr_n}, exp_pins(mc));
      rd_reg(`UMS_OFF_MODEM_CTL, v); chk(v, mc);
    end
    $display("test modem done");
    // Holding-empty follows the move to the shift register, idle needs both empty.
    pulse_load();
    rd_reg(ls, v); chk(v & 8'h60, 8'h60);
    tsr_e <= 1'b0; step(2);
    rd_reg(ls, v); chk(v & 8'h60, 8'h20);
    wr_reg(transmit_holding_register, 8'ha5); step(1);
    rd_reg(ls, v); chk(v & 8'h60, 8'h00);
    tsr_e <= 1'b1;
    wr_reg(`UMS_OFF_INT_EN, 8'h03);
    wr_reg(`UMS_OFF_EVT_ENABLE, 8'h03);
    pulse_load();
    chk({7'h00, irq}, 8'h01);
    wr_reg(transmit_holding_register, 8'h00);
    wr_reg(`UMS_OFF_EVT_CLEAR, 8'h02); step(2);
    chk({7'h00, irq}, 8'h00);
    wr_reg(`UMS_OFF_EVT_ENABLE, 8'h01);
    pulse_load();
    chk({7'h00, irq}, 8'h00);
    rd_reg(`UMS_OFF_EVT_STATUS, v); chk(v & 8'h02, 8'h02);
    wr_reg(transmit_holding_register, 8'h00);
    wr_reg(`UMS_OFF_EVT_CLEAR, 8'h02);
    $display("test transmit done");
    // A break needs more than 144 low samples at eight data bits; hold it well beyond.
    n_bpush = 0;
    // Five data bits, no parity, one stop: 96 samples, so 90 low samples are no break.
    wr_reg(`UMS_OFF_LINE_CTL, 8'h00);
    rd_reg(`UMS_OFF_LINE_CTL, v);
    chk(v, 8'h00);
    u_ums_line_partner.spacing(90);
    u_ums_line_partner.marking(16);
    chk(n_bpush[7:0], 8'h00);
    chk({7'h00, start_ok}, 8'h01);
    wr_reg(`UMS_OFF_LINE_CTL, 8'h03);
    u_ums_line_partner.spacing(200);
    #1 chk({7'h00, start_ok}, 8'h00);
    u_ums_line_partner.marking(4);
    #1 chk({7'h00, start_ok}, 8'h00);
    u_ums_line_partner.marking(12);
    #1 chk({7'h00, start_ok}, 8'h01);
    chk(n_bpush[7:0], 8'h01);
    chk({7'h00, irq}, 8'h01);
    wr_reg(ls, 8'hff);
    rd_reg(`UMS_OFF_EVT_STATUS, v); chk(v & 8'h01, 8'h01);
    rd_reg(ls, v); chk(v & 8'h90, 8'h10);
    rd_reg(ls, v); chk(v & 8'h10, 8'h00);
    push <= 1'b1; @(posedge clk); push <= 1'b0; step(2);
    rd_reg(ls, v); chk(v & 8'h02, 8'h02);
    $display("test break done");
    // FIFO mode: errors ride with their entries.
    do_reset();
    wr_reg(`UMS_OFF_FIFO_CTL, 8'h01); step(2);
    rd_reg(ls, v); chk(v & 8'h20, 8'h20);
    txf_e <= 1'b0;
    wr_reg(transmit_holding_register, 8'h11); step(1);
    rd_reg(ls, v); chk(v & 8'h20, 8'h00);
    push <= 1'b1; @(posedge clk); ferr <= 1'b1; perr <= 1'b1; @(posedge clk);
    push <= 1'b0; ferr <= 1'b0; perr <= 1'b0; step(2);
    rd_reg(ls, v); chk(v & 8'h8c, 8'h80);
    pop <= 1'b1; @(posedge clk); pop <= 1'b0; step(2);
    rd_reg(ls, v); chk(v & 8'h8c, 8'h8c);
    pop <= 1'b1; @(posedge clk); pop <= 1'b0; step(2);
    rd_reg(ls, v);
    rd_reg(ls, v); chk(v & 8'h8c, 8'h00);
    $display("test fifo done");
    stop_test();
  end

  // The whole run needs some 800 cycles; allow more than thirty times that.
  initial begin
    #120000;
    n_fail++;
    stop_test();
  end
endmodule

/* File: tb/ums_line_partner.sv */
// Purpose: Remote terminal that drives the received data line of the serial port.
// Assumes: The bench supplies the sample pulse of the baud divider.
// Notes: The line idles at the marking level, as an idle serial line does.
`timescale 1ns/1ns
module ums_line_partner (
  input wire logic i_clk_sys,
  input wire logic i_sample_en,
  output logic o_rxd
);
  // ************************************************************
  // Line driver
  // ************************************************************
  initial o_rxd = 1'b1;

  task automatic wait_samples(input int n);
    repeat (n) begin
      @(posedge i_clk_sys);
      while (i_sample_en !== 1'b1) @(posedge i_clk_sys);
    end
  endtask

  // Holds the spacing level for n samples, then returns the line to marking.
  task automatic spacing(input int n);
    o_rxd <= 1'b0;
    wait_samples(n);
    o_rxd <= 1'b1;
  endtask

  // Keeps marking for n samples before any new start bit may be sent.
  task automatic marking(input int n);
    o_rxd <= 1'b1;
    wait_samples(n);
  endtask
endmodule
